// file: tshc_top.sv
// tshc_top: host command/lock logic, mailbox, flags and touch sequencer
// assumes host ports and converter are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module tshc_top (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // host command and state
   input wire logic cmdWr,
   input wire logic [1:0] cmdCode,
   output logic [1:0] runState,
   output logic locked,
   // locked configuration write
   input wire logic cfgWr,
   input wire logic [7:0] cfgData,
   output logic [7:0] cfgValue,
   // local RAM host port
   input wire logic ramWr,
   input wire logic [2:0] ramAddr,
   input wire logic [15:0] ramWdata,
   output logic [15:0] ramRdata,
   // mailbox host port
   input wire logic mboxWr,
   input wire logic [2:0] mboxAddr,
   input wire logic [15:0] mboxWdata,
   output logic [15:0] mboxRdata,
   // host flags
   input wire logic [3:0] flagSet,
   input wire logic [3:0] flagClr,
   output logic [3:0] hostFlags,
   // touch controller controls
   input wire logic ctrlEnable,
   input wire logic convStart,
   input wire logic freeRun,
   input wire logic [2:0] gainSel,
   input wire logic [2:0] avgSel,
   input wire logic [1:0] prescSel,
   input wire logic mutualMode,
   input wire logic [7:0] sampleDelay,
   input wire logic [3:0] chanSel,
   input wire logic [7:0] chanDelay,
   // converter side
   input wire logic [9:0] adcCode,
   input wire logic adcDone,
   output logic adcStart,
   output logic adcClk,
   output logic integToAdc,
   output logic senseMutual,
   // results
   output logic [15:0] accResult,
   output logic resultValid
);
   import tshc_pkg::*;

   typedef struct packed {
      logic [1:0] runState;
      logic [1:0] pendState;
      logic [3:0] stDelay;
      logic locked;
      logic [7:0] cfg;
      logic [15:0] ramRd;
      logic [15:0] mboxRd;
      logic [3:0] flags;
      logic [4:0] srcCnt;
      logic [2:0] divCnt;
      logic adcClk;
      tshc_seq_t seq;
      logic [7:0] waitCnt;
      logic [3:0] lastChan;
      logic [6:0] avgCnt;
      logic [15:0] acc;
      logic [15:0] result;
      logic valid;
      logic adcStart;
   } tshc_state_t;

   tshc_state_t s_r;
   tshc_state_t s_nxt;
   logic [15:0] ram_r [MBOX_DEPTH];
   logic [15:0] mbox_r [MBOX_DEPTH];
   logic [6:0] avgTarget;
   logic [15:0] gained;
   logic srcTick;

   assign avgTarget = 7'(1) << ((avgSel > AVG_MAX) ? AVG_MAX : avgSel); // [RL14]
   assign gained = 16'(adcCode) << ((gainSel > 3'h5) ? 3'h5 : gainSel); // [RL14] [RL11]
   assign srcTick = (s_r.srcCnt == SRC_DIV - 5'h1);

   always_comb begin
      s_nxt = s_r;
      s_nxt.adcStart = 1'b0;
      s_nxt.valid = 1'b0;
      // command handling: delayed state update
      if (cmdWr && (cmdCode == CMD_START || cmdCode == CMD_STOP || cmdCode == CMD_RESET)) begin
         s_nxt.pendState = (cmdCode == CMD_START) ? RUN_RUNNING :
            (cmdCode == CMD_STOP) ? RUN_STOPPED : RUN_RESET; // [RL3] [RL20]
         s_nxt.stDelay = STATE_DELAY;
         if (cmdCode == CMD_START) begin
            s_nxt.locked = 1'b1; // [RL5] [RL6]
         end
      end else if (s_r.stDelay != 4'h0) begin
         s_nxt.stDelay = s_r.stDelay - 4'h1;
         if (s_r.stDelay == 4'h1) begin
            s_nxt.runState = s_r.pendState; // [RL4]
            if (s_r.pendState != RUN_RUNNING) begin
               s_nxt.locked = 1'b0; // [RL7] [RL8]
            end
         end
      end
      if (cfgWr && !s_r.locked) begin
         s_nxt.cfg = cfgData; // [RL2] [RL5]
      end
      s_nxt.ramRd = s_r.locked ? 16'h0000 : ram_r[ramAddr]; // [RL6]
      s_nxt.mboxRd = mbox_r[mboxAddr]; // [RL10]
      s_nxt.flags = (s_r.flags & ~flagClr) | flagSet; // [RL9]
      // prescaler: 4 MHz tick then divide by 1,2,4,8
      s_nxt.srcCnt = srcTick ? 5'h00 : s_r.srcCnt + 5'h01;
      if (srcTick) begin
         s_nxt.divCnt = s_r.divCnt + 3'h1;
      end
      s_nxt.adcClk = (prescSel == 2'h0) ? (s_r.srcCnt < (SRC_DIV >> 1)) :
         s_r.divCnt[prescSel - 2'h1]; // [RL15]
      // sampling sequencer
      unique case (s_r.seq)
         SEQ_IDLE: begin
            if (ctrlEnable && (convStart || freeRun)) begin // [RL13]
               s_nxt.acc = 16'h0000;
               s_nxt.avgCnt = 7'h00;
               s_nxt.waitCnt = (chanSel != s_r.lastChan) ? chanDelay : 8'h00;
               s_nxt.lastChan = chanSel;
               s_nxt.seq = SEQ_SETTLE; // [RL12] [RL18]
            end
         end
         SEQ_SETTLE: begin
            if (s_r.waitCnt == 8'h00) begin
               s_nxt.waitCnt = sampleDelay; // [RL17]
               s_nxt.seq = SEQ_DELAY;
            end else if (srcTick) begin
               s_nxt.waitCnt = s_r.waitCnt - 8'h01; // [RL18]
            end
         end
         SEQ_DELAY: begin
            if (s_r.waitCnt == 8'h00) begin
               s_nxt.adcStart = 1'b1;
               s_nxt.seq = SEQ_CONV;
            end else if (srcTick) begin
               s_nxt.waitCnt = s_r.waitCnt - 8'h01; // [RL17]
            end
         end
         SEQ_CONV: begin
            if (adcDone) begin
               s_nxt.acc = s_r.acc + gained; // [RL11]
               s_nxt.avgCnt = s_r.avgCnt + 7'h01;
               s_nxt.seq = SEQ_ACC;
            end
         end
         SEQ_ACC: begin
            if (s_r.avgCnt >= avgTarget) begin
               s_nxt.result = s_r.acc;
               s_nxt.valid = 1'b1;
               // free-run restarts from idle, single mode waits for convStart
               s_nxt.seq = SEQ_IDLE; // [RL13]
            end else begin
               s_nxt.waitCnt = sampleDelay; // [RL17]
               s_nxt.seq = SEQ_DELAY;
            end
         end
         default: s_nxt.seq = SEQ_IDLE;
      endcase
      if (!ctrlEnable) begin
         s_nxt.seq = SEQ_IDLE;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.runState <= RUN_RESET;
         s_r.pendState <= RUN_RESET;
         s_r.cfg <= CFG_RESET;
         s_r.seq <= SEQ_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (ramWr && !s_r.locked) begin
         ram_r[ramAddr] <= ramWdata; // [RL6]
      end
      if (mboxWr) begin
         mbox_r[mboxAddr] <= mboxWdata; // [RL10]
      end
   end

   assign runState = s_r.runState; // [RL1]
   assign locked = s_r.locked;
   assign cfgValue = s_r.cfg;
   assign ramRdata = s_r.ramRd;
   assign mboxRdata = s_r.mboxRd;
   assign hostFlags = s_r.flags;
   assign adcStart = s_r.adcStart;
   assign adcClk = s_r.adcClk;
   assign integToAdc = ctrlEnable; // [RL19]
   assign senseMutual = mutualMode; // [RL16]
   assign accResult = s_r.result;
   assign resultValid = s_r.valid;

   property p_start_locks;
      @(posedge mclk) disable iff (!resetn)
      (cmdWr && cmdCode == CMD_START) |=> locked;
   endproperty
   a_start_locks: assert property (p_start_locks) else $error("start did not lock"); // [RL5]

   property p_state_delay;
      @(posedge mclk) disable iff (!resetn)
      (cmdWr && cmdCode == CMD_STOP) ##1 !cmdWr [*8] |=> runState == RUN_STOPPED;
   endproperty
   a_state_delay: assert property (p_state_delay) else $error("state not updated"); // [RL4]

   property p_lock_hold;
      @(posedge mclk) disable iff (!resetn)
      (locked && runState == RUN_RUNNING && s_r.stDelay == 4'h0 &&
         !(cmdWr && cmdCode != CMD_START)) |=> locked;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock dropped early"); // [RL8]

   property p_cfg_blocked;
      @(posedge mclk) disable iff (!resetn)
      locked |=> $stable(cfgValue);
   endproperty
   a_cfg_blocked: assert property (p_cfg_blocked) else $error("locked cfg changed"); // [RL2]

   property p_bad_cmd;
      @(posedge mclk) disable iff (!resetn)
      (cmdWr && cmdCode == 2'h0 && s_r.stDelay == 4'h0) |=> $stable(runState) && $stable(locked);
   endproperty
   a_bad_cmd: assert property (p_bad_cmd) else $error("bad code acted"); // [RL20]

   property p_ram_read_locked;
      @(posedge mclk) disable iff (!resetn)
      locked |=> ramRdata == 16'h0000;
   endproperty
   a_ram_read_locked: assert property (p_ram_read_locked) else $error("ram visible"); // [RL6]

   property p_flag_set;
      @(posedge mclk) disable iff (!resetn)
      flagSet[0] |=> hostFlags[0];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag lost"); // [RL9]

   property p_route;
      @(posedge mclk) disable iff (!resetn)
      ctrlEnable |-> integToAdc;
   endproperty
   a_route: assert property (p_route) else $error("integrator not routed"); // [RL19]

   property p_unlock;
      @(posedge mclk) disable iff (!resetn)
      ($changed(runState) && runState != RUN_RUNNING) |-> !locked;
   endproperty
   a_unlock: assert property (p_unlock) else $error("lock not released"); // [RL7]

   property p_cmd_pending;
      @(posedge mclk) disable iff (!resetn)
      (cmdWr && cmdCode != 2'h0) |=> s_r.stDelay == STATE_DELAY;
   endproperty
   a_cmd_pending: assert property (p_cmd_pending) else $error("delay not armed"); // [RL4]

   property p_stop_keeps_lock;
      @(posedge mclk) disable iff (!resetn)
      (cmdWr && cmdCode == CMD_STOP && locked) |=> locked;
   endproperty
   a_stop_keeps_lock: assert property (p_stop_keeps_lock) else $error("lock dropped at write"); // [RL8]

   property p_cfg_free;
      @(posedge mclk) disable iff (!resetn)
      (cfgWr && !locked) |=> cfgValue == $past(cfgData);
   endproperty
   a_cfg_free: assert property (p_cfg_free) else $error("cfg write lost"); // [RL2]

   property p_mbox_read;
      @(posedge mclk) disable iff (!resetn)
      mboxWr ##1 (!mboxWr && $stable(mboxAddr)) |=> mboxRdata == $past(mboxWdata, 2);
   endproperty
   a_mbox_read: assert property (p_mbox_read) else $error("mailbox readback wrong"); // [RL10]

   property p_flag_clr;
      @(posedge mclk) disable iff (!resetn)
      (hostFlags[3] && flagClr[3] && !flagSet[3]) |=> !hostFlags[3];
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared"); // [RL9]

   property p_adc_start_pulse;
      @(posedge mclk) disable iff (!resetn)
      adcStart |=> !adcStart;
   endproperty
   a_adc_start_pulse: assert property (p_adc_start_pulse) else $error("start too long"); // [RL12]

   property p_valid_pulse;
      @(posedge mclk) disable iff (!resetn)
      resultValid |=> !resultValid;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long"); // [RL12]

   property p_seq_disable;
      @(posedge mclk) disable iff (!resetn)
      !ctrlEnable |=> s_r.seq == SEQ_IDLE;
   endproperty
   a_seq_disable: assert property (p_seq_disable) else $error("sequencer ran disabled"); // [RL12]

   property p_acc_on_done;
      @(posedge mclk) disable iff (!resetn)
      (s_r.seq == SEQ_CONV && adcDone && ctrlEnable) |=> s_r.acc == $past(s_r.acc) + $past(gained);
   endproperty
   a_acc_on_done: assert property (p_acc_on_done) else $error("sample not added"); // [RL11]

   property p_settle;
      @(posedge mclk) disable iff (!resetn)
      (s_r.seq == SEQ_IDLE && ctrlEnable && convStart && chanSel != s_r.lastChan)
         |=> s_r.waitCnt == $past(chanDelay);
   endproperty
   a_settle: assert property (p_settle) else $error("settle delay not loaded"); // [RL18]

   property p_sample_delay;
      @(posedge mclk) disable iff (!resetn)
      (s_r.seq == SEQ_SETTLE && s_r.waitCnt == 8'h00 && ctrlEnable)
         |=> s_r.waitCnt == $past(sampleDelay);
   endproperty
   a_sample_delay: assert property (p_sample_delay) else $error("sample delay not loaded"); // [RL17]

   property p_route_off;
      @(posedge mclk) disable iff (!resetn)
      !ctrlEnable |-> !integToAdc;
   endproperty
   a_route_off: assert property (p_route_off) else $error("integrator routed while off"); // [RL19]
endmodule : tshc_top
`default_nettype wire

// file: tshc_pkg.sv
// tshc_pkg: constants and types for the touch sensing host control block
// assumes a single 100 MHz clock and a host that polls the state port
//
// Behaviour
// [RL1] host reaches core through register-style command ports
// [RL2] some settings writable only while core stopped
// [RL3] valid start/stop/reset codes change run state
// [RL4] state output follows command after fixed delay
// [RL5] start locks run-time write-locked host settings
// [RL6] start also locks the local RAM
// [RL7] stop or reset removes both locks
// [RL8] lock drops only once state shows stopped; code also drops it once state shows reset after a reset command
// [RL9] core sets host flags, host reads them
// [RL10] host reads and writes the shared mailbox
// [RL11] 10-bit converter feeds 16-bit accumulator
// [RL12] state machine sequences sampling and accumulation
// [RL13] single or free-running conversion mode
// [RL14] gain up to 32, averaging up to 64
// [RL15] prescaler divides 4 MHz by 1,2,4,8
// [RL16] mutual or self sensing mode selectable
// [RL17] programmable sampling delay, changeable per cycle
// [RL18] channel change inserts settling delay
// [RL19] enabled controller routes integrator to converter
// [RL20] undefined command code changes nothing
package tshc_pkg;
   localparam logic [1:0] CMD_START = 2'h1;
   localparam logic [1:0] CMD_STOP = 2'h2;
   localparam logic [1:0] CMD_RESET = 2'h3;
   localparam logic [1:0] RUN_RESET = 2'h0;
   localparam logic [1:0] RUN_STOPPED = 2'h1;
   localparam logic [1:0] RUN_RUNNING = 2'h2;
   localparam logic [3:0] STATE_DELAY = 4'h8;
   localparam int CLK_MHZ = 100;
   localparam int SRC_MHZ = 4;
   localparam logic [4:0] SRC_DIV = 5'(CLK_MHZ / SRC_MHZ);
   localparam int MBOX_DEPTH = 8;
   localparam int ADC_BITS = 10;
   localparam int ACC_BITS = 16;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [2:0] AVG_MAX = 3'h6;
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000,
      SEQ_SETTLE = 3'b001,
      SEQ_DELAY = 3'b010,
      SEQ_CONV = 3'b011,
      SEQ_ACC = 3'b100
   } tshc_seq_t;
endpackage : tshc_pkg

// file: tshc_adc_model.sv
// tshc_adc_model: converter seen from the touch sequencer
// assumes adcStart is a one-cycle pulse synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module tshc_adc_model (
   // clock
   input wire logic mclk,
   // converter handshake
   input wire logic adcStart,
   input wire logic [3:0] lat,
   input wire logic [9:0] code,
   output logic [9:0] adcCode,
   output logic adcDone
);
   logic [3:0] cnt;
   logic busy;
   initial begin
      busy = 1'b0;
      cnt = 4'h0;
      adcDone = 1'b0;
      adcCode = 10'h000;
   end
   // code is only meaningful with adcDone; otherwise shows its inverse
   always @(posedge mclk) begin
      adcDone <= 1'b0;
      adcCode <= ~code;
      if (adcStart && !busy) begin
         busy <= 1'b1;
         cnt <= lat;
      end else if (busy && cnt == 4'h0) begin
         busy <= 1'b0;
         adcDone <= 1'b1;
         adcCode <= code;
      end else if (busy) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule : tshc_adc_model
`default_nettype wire

// file: touch_sensing_host_control_bench.sv
// touch_sensing_host_control_bench: commands, locks, mailbox, flags, sequencer
// assumes tshc_top and tshc_adc_model; inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module touch_sensing_host_control_bench;
   import tshc_pkg::*;
   logic mclk, resetn, cmdWr, cfgWr, ramWr, mboxWr, ctrlEnable, convStart, freeRun;
   logic mutualMode, locked, adcDone, adcStart, adcClk, integToAdc, senseMutual, resultValid;
   logic [1:0] cmdCode, runState, prescSel;
   logic [7:0] cfgData, cfgValue, sampleDelay, chanDelay;
   logic [2:0] ramAddr, mboxAddr, gainSel, avgSel;
   logic [15:0] ramWdata, ramRdata, mboxWdata, mboxRdata, accResult, ramKeep;
   logic [3:0] flagSet, flagClr, hostFlags, chanSel, lat;
   logic [9:0] adcCode, code;
   logic [15:0] mbox [8];
   logic [31:0] seed;
   int error_cnt, total_checks, i, k;
   tshc_top dut (.mclk(mclk), .resetn(resetn), .cmdWr(cmdWr), .cmdCode(cmdCode),
      .runState(runState), .locked(locked), .cfgWr(cfgWr), .cfgData(cfgData),
      .cfgValue(cfgValue), .ramWr(ramWr), .ramAddr(ramAddr), .ramWdata(ramWdata),
      .ramRdata(ramRdata), .mboxWr(mboxWr), .mboxAddr(mboxAddr), .mboxWdata(mboxWdata),
      .mboxRdata(mboxRdata), .flagSet(flagSet), .flagClr(flagClr), .hostFlags(hostFlags),
      .ctrlEnable(ctrlEnable), .convStart(convStart), .freeRun(freeRun), .gainSel(gainSel),
      .avgSel(avgSel), .prescSel(prescSel), .mutualMode(mutualMode),
      .sampleDelay(sampleDelay), .chanSel(chanSel), .chanDelay(chanDelay),
      .adcCode(adcCode), .adcDone(adcDone), .adcStart(adcStart), .adcClk(adcClk),
      .integToAdc(integToAdc), .senseMutual(senseMutual), .accResult(accResult),
      .resultValid(resultValid));
   tshc_adc_model adc (.mclk(mclk), .adcStart(adcStart), .lat(lat), .code(code),
      .adcCode(adcCode), .adcDone(adcDone));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [15:0] expAcc(input logic [9:0] c, input logic [2:0] g,
         input logic [2:0] a);
      return 16'((32'(c) << g) << a);
   endfunction : expAcc
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: saw %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   task automatic issue(input logic [1:0] c, input logic [1:0] s0, input logic [1:0] s1,
         input logic l0, input logic l1);
      @(negedge mclk) {cmdWr, cmdCode} = {1'b1, c};
      @(negedge mclk) cmdWr = 1'b0;
      for (k = 1; k <= 9; k++) begin
         @(negedge mclk);
         chk(16'(runState), 16'((k >= 8) ? s1 : s0));
         chk(16'(locked), 16'((k >= 8) ? l1 : l0));
      end
   endtask : issue
   task automatic wrAll(input logic [7:0] cfg, input logic [15:0] rd);
      @(negedge mclk) {cfgWr, cfgData, ramWr, ramAddr, ramWdata} = {1'b1, cfg, 1'b1, 3'h3, rd};
      @(negedge mclk) {cfgWr, ramWr} = 2'h0;
   endtask : wrAll
   task automatic rdAll(input logic [7:0] cfg, input logic [15:0] rd);
      @(negedge mclk);
      chk(16'(cfgValue), 16'(cfg));
      chk(ramRdata, rd);
   endtask : rdAll
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      {resetn, cmdWr, cfgWr, ramWr, mboxWr, ctrlEnable, convStart, freeRun} = 8'h00;
      {cmdCode, prescSel, mutualMode, cfgData, ramAddr, mboxAddr, gainSel, avgSel} = '0;
      {ramWdata, mboxWdata, flagSet, flagClr, sampleDelay, chanDelay, chanSel} = '0;
      {lat, code} = '0;
      seed = 32'd39926;
      error_cnt = 0;
      total_checks = 0;
      repeat (10) @(negedge mclk);
      resetn = 1'b1;
      chk(16'({runState, locked}), 16'h0000);
      ramKeep = rnd();
      wrAll(8'hA5, ramKeep);
      rdAll(8'hA5, ramKeep);
      issue(CMD_START, RUN_RESET, RUN_RUNNING, 1'b1, 1'b1);
      wrAll(8'h5A, ~ramKeep);
      rdAll(8'hA5, 16'h0000);
      issue(2'h0, RUN_RUNNING, RUN_RUNNING, 1'b1, 1'b1);
      issue(CMD_STOP, RUN_RUNNING, RUN_STOPPED, 1'b1, 1'b0);
      rdAll(8'hA5, ramKeep);
      wrAll(8'h5A, ramKeep);
      rdAll(8'h5A, ramKeep);
      issue(CMD_START, RUN_STOPPED, RUN_RUNNING, 1'b1, 1'b1);
      issue(CMD_RESET, RUN_RUNNING, RUN_RESET, 1'b1, 1'b0);
      for (i = 0; i < 8; i++) begin
         mbox[i] = 16'(rnd());
         @(negedge mclk) {mboxWr, mboxAddr, mboxWdata} = {1'b1, 3'(i), mbox[i]};
      end
      @(negedge mclk) mboxWr = 1'b0;
      for (i = 7; i >= 0; i--) begin
         @(negedge mclk) mboxAddr = 3'(i);
         @(negedge mclk) chk(mboxRdata, mbox[i]);
      end
      @(negedge mclk) flagSet = 4'hA;
      @(negedge mclk) {flagSet, flagClr} = 8'h2A;
      @(negedge mclk) {flagSet, flagClr} = 8'h00;
      chk(16'(hostFlags), 16'h2);
      {ctrlEnable, mutualMode, chanSel, chanDelay, sampleDelay} = {2'h3, 4'h1, 8'h01, 8'h01};
      @(negedge mclk) chk(16'({integToAdc, senseMutual}), 16'h3);
      for (i = 0; i < 2; i++) begin
         {lat, code} = {4'(i * 9), 10'(rnd())};
         {gainSel, avgSel} = {3'(i * 2), 3'(i)};
         @(negedge mclk) convStart = 1'b1;
         @(negedge mclk) convStart = 1'b0;
         for (k = 0; k < 3000 && resultValid !== 1'b1; k++) @(negedge mclk);
         if (k == 3000) begin
            error_cnt++;
            complete_run();
         end
         chk(accResult, expAcc(code, gainSel, avgSel));
      end
      complete_run();
   end
endmodule : touch_sensing_host_control_bench
`default_nettype wire
